// ### src/rms_pkg.sv
// Constants and types for the reset mode and pin state block
package rms_pkg;

    // ------------------------------------------------------------
    // Sequencer phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RMS_HOLD    = 2'h0,
        RMS_MODESEL = 2'h1,
        RMS_EXCPROC = 2'h3,
        RMS_RUN     = 2'h2
    } rms_phase_t;

    // ------------------------------------------------------------
    // Mode-select bit positions on the data bus
    // ------------------------------------------------------------
    localparam int RMS_DATA_LINE_ONE = 1;
    localparam int RMS_PORT_E_SEL = 8;
    localparam int RMS_PORT_F_SEL = 9;
    localparam int RMS_DATA_LINE_TEN = 10;

    // ------------------------------------------------------------
    // Widths and values after reset
    // ------------------------------------------------------------
    localparam int RMS_ADDR_W = 24;
    localparam int RMS_PORT_DIR_W = 48;
    localparam int RMS_CS_W = 11;
    localparam int RMS_BUS_CTRL_W = 6;
    localparam int RMS_TIMER_CH = 16;
    localparam logic [RMS_ADDR_W-1:0] RMS_ADDR_RST = 24'hFFFFFF;
    localparam logic [RMS_BUS_CTRL_W-1:0] RMS_BUS_CTRL_RST = 6'h3F;
    localparam logic [RMS_CS_W-1:0] RMS_CS_RST = 11'h7FF;
    localparam logic [RMS_PORT_DIR_W-1:0] RMS_PORT_DIR_RST = 48'h000000000000;
    localparam logic [7:0] RMS_CONV_DIR_RST = 8'h00;
    localparam logic [7:0] RMS_SERIAL_DIR_RST = 8'h00;
    localparam logic [RMS_TIMER_CH-1:0] RMS_TIMER_IO_RST = 16'hFFFF;
    localparam logic [15:0] RMS_DATA_OE_RST = 16'h0000;

endpackage

// ### src/rms_strap_if.sv
// Latched mode-select straps passed from the latch to the sequencer
`timescale 1ns/1ps
interface rms_strap_if;
    logic [15:0] dataStrap;
    logic busErrorStrap;
    logic clockModeStrap;
    logic threeStateStrap;
    logic bkptIntStrapN;
    logic bkptExtStrapN;
    logic strapValid;

    modport latch (
        output dataStrap, busErrorStrap, clockModeStrap, threeStateStrap,
        output bkptIntStrapN, bkptExtStrapN, strapValid
    );
    modport user (
        input dataStrap, busErrorStrap, clockModeStrap, threeStateStrap,
        input bkptIntStrapN, bkptExtStrapN, strapValid
    );
endinterface

// ### src/rms_strap_latch.sv
// Mode-select strap latch, frozen at reset release
`timescale 1ns/1ps
module rms_strap_latch (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] dataIn,
    input wire logic busErrorInput,
    input wire logic clockModeSelect,
    input wire logic threeStateControl,
    input wire logic breakpointRequestIntN,
    input wire logic breakpointRequestExtN,
    rms_strap_if.latch strap
);
    logic [15:0] next_dataStrap;
    logic next_busErrorStrap;
    logic next_clockModeStrap;
    logic next_threeStateStrap;
    logic next_bkptIntStrapN;
    logic next_bkptExtStrapN;
    logic next_strapValid;

    // ------------------------------------------------------------
    // Follow pins in reset, hold after release; breakpoint straps follow one clock longer
    // ------------------------------------------------------------
    always_comb begin
        next_dataStrap = strap.dataStrap;
        next_busErrorStrap = strap.busErrorStrap;
        next_clockModeStrap = strap.clockModeStrap;
        next_threeStateStrap = strap.threeStateStrap;
        next_bkptIntStrapN = strap.bkptIntStrapN;
        next_bkptExtStrapN = strap.bkptExtStrapN;
        next_strapValid = 1'b1;
        if (!rstn) begin
            next_dataStrap = dataIn;
            next_busErrorStrap = busErrorInput;
            next_clockModeStrap = clockModeSelect;
            next_threeStateStrap = threeStateControl;
            next_strapValid = 1'b0;
        end
        if (!rstn || !strap.strapValid) begin
            next_bkptIntStrapN = breakpointRequestIntN;
            next_bkptExtStrapN = breakpointRequestExtN;
        end
    end

    always_ff @(posedge clk_sys) begin
        strap.dataStrap <= next_dataStrap;
        strap.busErrorStrap <= next_busErrorStrap;
        strap.clockModeStrap <= next_clockModeStrap;
        strap.threeStateStrap <= next_threeStateStrap;
        strap.bkptIntStrapN <= next_bkptIntStrapN;
        strap.bkptExtStrapN <= next_bkptExtStrapN;
        strap.strapValid <= next_strapValid;
    end
endmodule

// ### src/rms_reset_mode.sv
// Reset mode capture and pin state sequencer, top level
// How it works
// - Sample both breakpoint requests at reset release
// - Either low: set debug flag, later breakpoints enter debug
// - Both high: later breakpoints raise exceptions
// - Data ten, one low, error high: emulation
// - Emulation sends port register accesses external
// - Ports default inputs, alternate functions disabled
// - Converter, serial, timer, debug pins default set
// - In reset data inputs, bus pins driven high
// - Port-assigned bus pins leave reset as inputs
// - Release: mode select, then exception processing
// - Outputs operate only after reset release
// - Pin functions follow bus config and straps
// - Chip selects high in reset, boot low after
// - Module port pins settle to high-impedance inputs
// - Module pins inputs, debug pins carry debug signals
// - Bus error low in reset selects single-chip
`timescale 1ns/1ps
module rms_reset_mode (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] dataIn,
    input wire logic busErrorInput,
    input wire logic clockModeSelect,
    input wire logic threeStateControl,
    input wire logic breakpointRequestIntN,
    input wire logic breakpointRequestExtN,
    input wire logic portRegAccess,
    input wire logic portDirWrite,
    input wire logic [rms_pkg::RMS_PORT_DIR_W-1:0] portDirWriteData,
    output logic [15:0] dataBusOe,
    output logic [rms_pkg::RMS_ADDR_W-1:0] addrOut,
    output logic addrOe,
    output logic [rms_pkg::RMS_BUS_CTRL_W-1:0] busCtrlOut,
    output logic busCtrlOe,
    output logic [rms_pkg::RMS_CS_W-1:0] chipSelectN,
    output logic bootChipSelectN,
    output logic emulationChipSelectMN,
    output logic emulationChipSelectEN,
    output logic [rms_pkg::RMS_PORT_DIR_W-1:0] portDir,
    output logic altFuncEnable,
    output logic busCtrlAsPort,
    output logic irqAsPort,
    output logic [7:0] converterPortDir,
    output logic [7:0] serialPortDir,
    output logic serialReceiveSel,
    output logic [rms_pkg::RMS_TIMER_CH-1:0] timerChannelIo,
    output logic timerExternalClockIn,
    output logic debugPinsDebug,
    output logic outputsActive,
    output logic singleChipMode,
    output logic emulationMode,
    output logic clockModeLatched,
    output logic backgroundDebugFlag,
    output logic resetExceptionStart,
    output logic enterBackgroundDebug,
    output logic breakpointException,
    output logic accessExternal
);
    import rms_pkg::*;

    rms_strap_if strap ();

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    rms_strap_latch u_strap (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .dataIn(dataIn),
        .busErrorInput(busErrorInput),
        .clockModeSelect(clockModeSelect),
        .threeStateControl(threeStateControl),
        .breakpointRequestIntN(breakpointRequestIntN),
        .breakpointRequestExtN(breakpointRequestExtN),
        .strap(strap)
    );

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    rms_phase_t phase;
    rms_phase_t next_phase;
    logic next_resetExceptionStart;

    always_comb begin
        next_phase = phase;
        next_resetExceptionStart = 1'b0;
        case (phase)
            RMS_HOLD: begin
                next_phase = RMS_MODESEL;
            end
            RMS_MODESEL: begin
                next_phase = RMS_EXCPROC;
                next_resetExceptionStart = 1'b1;
            end
            RMS_EXCPROC: begin
                next_phase = RMS_RUN;
            end
            RMS_RUN: begin
                next_phase = RMS_RUN;
            end
            default: begin
                next_phase = RMS_HOLD;
            end
        endcase
        if (!rstn) begin
            next_phase = RMS_HOLD;
            next_resetExceptionStart = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        phase <= next_phase;
        resetExceptionStart <= next_resetExceptionStart;
    end

    // ------------------------------------------------------------
    // Mode decode and breakpoint handling
    // ------------------------------------------------------------
    logic next_singleChipMode;
    logic next_emulationMode;
    logic next_clockModeLatched;
    logic next_backgroundDebugFlag;
    logic next_enterBackgroundDebug;
    logic next_breakpointException;
    logic next_accessExternal;
    logic bkptPrev;
    logic next_bkptPrev;
    logic bkptNow;

    always_comb begin
        bkptNow = !breakpointRequestIntN || !breakpointRequestExtN;
        next_bkptPrev = bkptNow;
        next_singleChipMode = singleChipMode;
        next_emulationMode = emulationMode;
        next_clockModeLatched = clockModeLatched;
        next_backgroundDebugFlag = backgroundDebugFlag;
        next_enterBackgroundDebug = 1'b0;
        next_breakpointException = 1'b0;
        next_accessExternal = 1'b0;
        if (phase == RMS_MODESEL) begin
            next_singleChipMode = !strap.busErrorStrap;
            next_emulationMode = !strap.dataStrap[RMS_DATA_LINE_TEN] &&
                strap.busErrorStrap && !strap.dataStrap[RMS_DATA_LINE_ONE];
            next_clockModeLatched = strap.clockModeStrap;
            next_backgroundDebugFlag = !strap.bkptIntStrapN || !strap.bkptExtStrapN;
        end
        if (phase == RMS_RUN && bkptNow && !bkptPrev) begin
            if (backgroundDebugFlag) begin
                next_enterBackgroundDebug = 1'b1;
            end else begin
                next_breakpointException = 1'b1;
            end
        end
        if (phase == RMS_RUN && emulationMode && portRegAccess) begin
            next_accessExternal = 1'b1;
        end
        if (!rstn) begin
            next_singleChipMode = 1'b0;
            next_emulationMode = 1'b0;
            next_clockModeLatched = 1'b0;
            next_backgroundDebugFlag = 1'b0;
            next_bkptPrev = 1'b1;
            next_enterBackgroundDebug = 1'b0;
            next_breakpointException = 1'b0;
            next_accessExternal = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        bkptPrev <= next_bkptPrev;
        singleChipMode <= next_singleChipMode;
        emulationMode <= next_emulationMode;
        clockModeLatched <= next_clockModeLatched;
        backgroundDebugFlag <= next_backgroundDebugFlag;
        enterBackgroundDebug <= next_enterBackgroundDebug;
        breakpointException <= next_breakpointException;
        accessExternal <= next_accessExternal;
    end

    // ------------------------------------------------------------
    // Bus and chip-select pin states
    // ------------------------------------------------------------
    logic [15:0] next_dataBusOe;
    logic [RMS_ADDR_W-1:0] next_addrOut;
    logic next_addrOe;
    logic [RMS_BUS_CTRL_W-1:0] next_busCtrlOut;
    logic next_busCtrlOe;
    logic [RMS_CS_W-1:0] next_chipSelectN;
    logic next_bootChipSelectN;
    logic next_outputsActive;
    logic next_busCtrlAsPort;
    logic next_irqAsPort;
    logic released;

    always_comb begin
        released = rstn && phase != RMS_HOLD && phase != RMS_MODESEL;
        next_dataBusOe = RMS_DATA_OE_RST;
        next_addrOut = RMS_ADDR_RST;
        next_busCtrlOut = RMS_BUS_CTRL_RST;
        next_chipSelectN = RMS_CS_RST;
        // address and bus control driven high in reset
        next_addrOe = 1'b1;
        next_busCtrlOe = 1'b1;
        next_bootChipSelectN = 1'b1;
        next_outputsActive = 1'b0;
        next_busCtrlAsPort = 1'b0;
        next_irqAsPort = 1'b0;
        if (released) begin
            next_outputsActive = 1'b1;
            next_bootChipSelectN = 1'b0;
            // function from bus config and straps
            next_busCtrlAsPort = singleChipMode || !strap.dataStrap[RMS_PORT_E_SEL];
            next_irqAsPort = singleChipMode || !strap.dataStrap[RMS_PORT_F_SEL];
            next_addrOe = !singleChipMode;
            next_busCtrlOe = !next_busCtrlAsPort;
        end
    end

    always_ff @(posedge clk_sys) begin
        dataBusOe <= next_dataBusOe;
        addrOut <= next_addrOut;
        addrOe <= next_addrOe;
        busCtrlOut <= next_busCtrlOut;
        busCtrlOe <= next_busCtrlOe;
        chipSelectN <= next_chipSelectN;
        bootChipSelectN <= next_bootChipSelectN;
        emulationChipSelectMN <= 1'b1;
        emulationChipSelectEN <= 1'b1;
        outputsActive <= next_outputsActive;
        busCtrlAsPort <= next_busCtrlAsPort;
        irqAsPort <= next_irqAsPort;
    end

    // ------------------------------------------------------------
    // Module pin configuration
    // ------------------------------------------------------------
    logic [RMS_PORT_DIR_W-1:0] next_portDir;

    always_comb begin
        next_portDir = portDir;
        if (phase == RMS_RUN && portDirWrite) begin
            next_portDir = portDirWriteData;
        end
        if (!rstn) begin
            next_portDir = RMS_PORT_DIR_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        portDir <= next_portDir;
        altFuncEnable <= 1'b0;
        converterPortDir <= RMS_CONV_DIR_RST;
        serialPortDir <= RMS_SERIAL_DIR_RST;
        serialReceiveSel <= 1'b1;
        // timer channels, clock input, debug pins
        timerChannelIo <= RMS_TIMER_IO_RST;
        timerExternalClockIn <= 1'b1;
        debugPinsDebug <= 1'b1;
    end
endmodule

// ### verif/rms_strap_model.sv
// Far-side logic that drives the mode-select straps
`timescale 1ns/1ps
module rms_strap_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [18:0] strap,
    output logic [15:0] dataIn,
    output logic busErrorInput,
    output logic clockModeSelect,
    output logic threeStateControl
);
    // ----------------------------------------
    // Strap drive
    // ----------------------------------------
    // levels driven, never floating
    always @(negedge clk_sys) begin
        if (!rstn) begin
            {threeStateControl, clockModeSelect, busErrorInput, dataIn} <= strap;
        end else begin
            dataIn <= ~dataIn;
        end
    end
endmodule

// ### verif/rms_reset_mode_properties.sv
// Concurrent checks on the reset mode and pin state block
`timescale 1ns/1ps
module rms_reset_mode_properties (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] dataIn,
    input wire logic busErrorInput,
    input wire logic breakpointRequestIntN,
    input wire logic breakpointRequestExtN,
    input wire logic portRegAccess,
    input wire logic singleChipMode,
    input wire logic emulationMode,
    input wire logic bootChipSelectN,
    input wire logic outputsActive,
    input wire logic backgroundDebugFlag,
    input wire logic resetExceptionStart,
    input wire logic enterBackgroundDebug,
    input wire logic breakpointException,
    input wire logic accessExternal
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    logic [15:0] strapData;
    logic strapBerr;
    // ----------------------------------------
    // Strap copy at the last reset edge
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            strapData <= dataIn;
            strapBerr <= busErrorInput;
        end
    end
    start_pulse_a: assert property (
        $rose(rstn) |-> !resetExceptionStart ##2 resetExceptionStart ##1 !resetExceptionStart)
        else $error("reset exception start misplaced");
    outputs_late_a: assert property (
        $rose(rstn) |-> !outputsActive [*3] ##1 outputsActive) else $error("outputs start early");
    boot_select_a: assert property (
        $rose(rstn) |-> bootChipSelectN [*3] ##1 !bootChipSelectN) else $error("boot select");
    breakpoint_request_sample_a: assert property (
        $rose(rstn) |-> ##2 backgroundDebugFlag == !($past(breakpointRequestIntN, 2)
        && $past(breakpointRequestExtN, 2))) else $error("debug flag sample wrong");
    debug_entry_a: assert property (
        enterBackgroundDebug |-> backgroundDebugFlag) else $error("debug entry without flag");
    breakpoint_request_exception_a: assert property (
        breakpointException |-> !backgroundDebugFlag) else $error("exception with flag set");
    breakpoint_request_answer_a: assert property (
        outputsActive && $past(breakpointRequestIntN) && $past(breakpointRequestExtN)
        && !(breakpointRequestIntN && breakpointRequestExtN)
        |=> (enterBackgroundDebug ^ breakpointException)) else $error("breakpoint unanswered");
    breakpoint_request_pulse_a: assert property (
        (enterBackgroundDebug || breakpointException)
        |=> !(enterBackgroundDebug || breakpointException)) else $error("breakpoint pulse long");
    strap_decode_a: assert property (
        outputsActive |-> emulationMode == (!strapData[10] && strapBerr && !strapData[1])
        && singleChipMode == !strapBerr) else $error("mode decode wrong");
    reset_pins_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        !rstn |=> bootChipSelectN && !outputsActive && !enterBackgroundDebug
        && !breakpointException && !accessExternal) else $error("pins active in reset");
    access_ext_a: assert property (
        outputsActive |=> accessExternal == ($past(portRegAccess) && emulationMode))
        else $error("external access wrong");
endmodule
bind rms_reset_mode rms_reset_mode_properties u_props (
    .clk_sys, .rstn, .dataIn, .busErrorInput, .breakpointRequestIntN, .breakpointRequestExtN,
    .portRegAccess, .singleChipMode, .emulationMode, .bootChipSelectN, .outputsActive,
    .backgroundDebugFlag, .resetExceptionStart, .enterBackgroundDebug, .breakpointException,
    .accessExternal
);

// ### verif/rms_reset_mode_tb.sv
// Self-checking bench for the reset mode and pin state block
`timescale 1ns/1ps
module rms_reset_mode_tb;
    import rms_pkg::*;
    logic clk_sys, rstn, bkIntN, bkExtN, portRegAccess, portDirWrite, busErrorInput;
    logic clockModeSelect, threeStateControl, addrOe, busCtrlOe, bootChipSelectN;
    logic altFuncEnable, busCtrlAsPort, irqAsPort, serialReceiveSel, timerExternalClockIn;
    logic debugPinsDebug, outputsActive, singleChipMode, emulationMode, clockModeLatched;
    logic backgroundDebugFlag, resetExceptionStart, enterBackgroundDebug, breakpointException;
    logic accessExternal, emulationChipSelectMN, emulationChipSelectEN;
    logic [15:0] dataIn, dataBusOe;
    logic [18:0] strap;
    logic [RMS_ADDR_W-1:0] addrOut;
    logic [RMS_BUS_CTRL_W-1:0] busCtrlOut;
    logic [RMS_CS_W-1:0] chipSelectN;
    logic [RMS_PORT_DIR_W-1:0] portDir, portDirWriteData;
    logic [7:0] converterPortDir, serialPortDir;
    logic [RMS_TIMER_CH-1:0] timerChannelIo;
    logic [31:0] lfsr;
    int fail_count, comparisons, cycles;

    rms_reset_mode u_dut (
        .clk_sys, .rstn, .dataIn, .busErrorInput, .clockModeSelect, .threeStateControl,
        .breakpointRequestIntN(bkIntN), .breakpointRequestExtN(bkExtN), .portRegAccess,
        .portDirWrite, .portDirWriteData, .dataBusOe, .addrOut, .addrOe, .busCtrlOut,
        .busCtrlOe, .chipSelectN, .bootChipSelectN, .emulationChipSelectMN,
        .emulationChipSelectEN, .portDir, .altFuncEnable, .busCtrlAsPort, .irqAsPort,
        .converterPortDir, .serialPortDir, .serialReceiveSel, .timerChannelIo,
        .timerExternalClockIn, .debugPinsDebug, .outputsActive, .singleChipMode,
        .emulationMode, .clockModeLatched, .backgroundDebugFlag, .resetExceptionStart,
        .enterBackgroundDebug, .breakpointException, .accessExternal
    );
    rms_strap_model u_straps (
        .clk_sys, .rstn, .strap, .dataIn, .busErrorInput, .clockModeSelect, .threeStateControl
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // Modes: single, emulation, ctrl port, irq port, clock, address drive
    function automatic logic [5:0] exp_modes(input logic [18:0] s);
        logic sc;
        sc = !s[16];
        return {sc, !s[10] && s[16] && !s[1], sc || !s[8], sc || !s[9], s[17], !sc};
    endfunction

    task automatic run_case(input logic [18:0] s, input logic [1:0] bk);
        logic [5:0] m;
        logic dbg;
        logic [RMS_PORT_DIR_W-1:0] pd;
        m = exp_modes(s);
        dbg = !(bk[0] && bk[1]);
        @(negedge clk_sys);
        rstn <= 1'b0;
        strap <= s;
        bkIntN <= bk[0];
        bkExtN <= bk[1];
        repeat (3) @(negedge clk_sys);
        chk({dataBusOe, addrOe, busCtrlOe, addrOut, busCtrlOut}, {16'h0000, 32'hFFFFFFFF});
        chk({chipSelectN, bootChipSelectN, outputsActive, resetExceptionStart}, 14'h3FFC);
        chk({portDir, altFuncEnable, backgroundDebugFlag, emulationMode}, 51'h0);
        rstn <= 1'b1;
        @(negedge clk_sys);
        bkIntN <= 1'b1;
        bkExtN <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({singleChipMode, emulationMode, busCtrlAsPort, irqAsPort, clockModeLatched, addrOe},
            m);
        chk({busCtrlOe, bootChipSelectN, outputsActive, backgroundDebugFlag},
            {!m[3], 2'h1, dbg});
        chk({converterPortDir, serialPortDir, serialReceiveSel, timerChannelIo},
            {16'h0000, 1'b1, 16'hFFFF});
        chk({timerExternalClockIn, debugPinsDebug, emulationChipSelectMN, emulationChipSelectEN},
            4'hF);
        chk({chipSelectN, dataBusOe, addrOut, busCtrlOut},
            {11'h7FF, 16'h0000, 24'hFFFFFF, 6'h3F});
        lfsr = next_rand(lfsr);
        bkIntN <= lfsr[0];
        bkExtN <= !lfsr[0];
        @(negedge clk_sys);
        bkIntN <= 1'b1;
        bkExtN <= 1'b1;
        chk({enterBackgroundDebug, breakpointException}, {dbg, !dbg});
        portRegAccess <= 1'b1;
        @(negedge clk_sys);
        portRegAccess <= 1'b0;
        chk(accessExternal, m[4]);
        lfsr = next_rand(lfsr);
        pd = {lfsr[15:0], next_rand(lfsr)};
        portDirWriteData <= pd;
        portDirWrite <= 1'b1;
        @(negedge clk_sys);
        portDirWrite <= 1'b0;
        chk(portDir, pd);
        chk({singleChipMode, emulationMode, busCtrlAsPort, irqAsPort, clockModeLatched, addrOe},
            m);
    endtask

    initial begin
        rstn = 1'b0;
        strap = 19'h00000;
        bkIntN = 1'b1;
        bkExtN = 1'b1;
        portRegAccess = 1'b0;
        portDirWrite = 1'b0;
        portDirWriteData = 48'h000000000000;
        lfsr = 32'h94567723;
        fail_count = 0;
        comparisons = 0;
        cycles = 0;
        run_case(19'h7FFFF, 2'h3);
        run_case(19'h1FBFD, 2'h2);
        run_case(19'h6FFFF, 2'h1);
        run_case(19'h1FCFF, 2'h0);
        repeat (6) begin
            lfsr = next_rand(lfsr);
            run_case(lfsr[18:0], lfsr[20:19]);
        end
        print_verdict();
    end
endmodule
